// File: rcpm_top.v
// Reset configuration capture and low-power mode control.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rcpm_defines.vh"
// Operation
// - Configuration enable is active low; high disables strap sampling except clock mode and debug select.
// - Operating-mode straps 111 select master; other patterns reserved.
// - Boot straps 00/11 32-bit, 10 8-bit, 01 16-bit.
// - Drive strap 1 gives full drive, 0 partial.
// - Clock mode 00 no loop, 01 1:1, 10 external ref, 11 crystal.
// - Two straps pick address lines or one to three extra chip selects.
// - Debug select 0 routes to background debug, 1 to boundary scan.
// - Without straps, partial drive and 16-bit boot.
// - Stop instruction enters the mode held in the low-power field.
// - Low-power field goes out to system and clock control.
// - Deepest stop halts all clocks, system clock parked low.
// - Breakpoint, debug request or interrupt wakes back to run.
// - Wait gates only core and memory clocks.
// - Doze stops core like wait, with its own field code.
// - Doze peripherals may wake; halted ones restart on exit.
// - Peripherals keep state across stop and resume.
// - Disabled peripherals stop clocks and stay off in every mode.
// - Software can shut down the bus clock output independently.
module rcpm_top (
  input  wire                        I_SYS_CLK,
  input  wire                        I_RST_N,
  input  wire [`RCPM_ADDR_W-1:0]     I_ADDR,
  input  wire [31:0]                 I_WDATA,
  input  wire                        I_WR,
  input  wire                        I_RD,
  input  wire                        I_CFG_STRAP_ENABLE_N,
  input  wire [2:0]                  I_OPMODE_STRAP,
  input  wire [1:0]                  I_BOOT_STRAP,
  input  wire                        I_DRIVE_STRAP,
  input  wire                        I_CLOCK_MODE_SEL_HI,
  input  wire                        I_CLOCK_MODE_SEL_LO,
  input  wire [1:0]                  I_CS_STRAP,
  input  wire                        I_DEBUG_SEL,
  input  wire                        I_STOP_INSN,
  input  wire                        I_BREAKPOINT_REQUEST_N,
  input  wire                        I_DEBUG_REQ,
  input  wire                        I_IRQ_VALID,
  output reg  [31:0]                 O_RDATA,
  output reg                         O_MASTER_MODE,
  output reg                         O_OPMODE_RESERVED,
  output reg  [1:0]                  O_BOOT_SIZE,
  output reg                         O_FULL_DRIVE,
  output reg  [1:0]                  O_CLOCK_MODE,
  output reg  [2:0]                  O_CS_ENABLE,
  output reg                         O_JTAG_SEL,
  output reg  [1:0]                  O_LOW_POWER_MODE_FIELD,
  output reg                         O_CORE_CLK_EN,
  output reg                         O_MEM_CLK_EN,
  output reg                         O_SYS_CLK_EN,
  output reg                         O_BUS_CLOCK_OUTPUT_EN,
  output reg  [`RCPM_PERIPH_W-1:0]   O_PERIPH_CLK_EN,
  output reg                         O_LOW_POWER_ACTIVE
);

  localparam ST_RUN  = 1'b0;
  localparam ST_IDLE = 1'b1;

  reg                       rst_seen_q;
  reg                       cfg_done_q;
  reg  [1:0]                lpm_q;
  reg                       cko_off_q;
  reg  [`RCPM_PERIPH_W-1:0] periph_dis_q;
  reg                       state_q;
  reg                       state_d;
  reg  [1:0]                boot_d;
  reg  [2:0]                cs_d;
  wire                      wake;
  wire                      in_stop;

  // Boot size code from the two boot straps.
  function [1:0] dec_boot;
    input [1:0] s;
    begin
      case (s)
        2'h2:    dec_boot = `RCPM_BOOT_8;
        2'h1:    dec_boot = `RCPM_BOOT_16;
        default: dec_boot = `RCPM_BOOT_32;
      endcase
    end
  endfunction

  assign wake    = ~I_BREAKPOINT_REQUEST_N | I_DEBUG_REQ | I_IRQ_VALID;
  assign in_stop = (state_q == ST_IDLE) && (lpm_q == `RCPM_LPM_STOP);

  always @* begin
    boot_d = dec_boot(I_BOOT_STRAP);
    case (I_CS_STRAP)
      2'h1:    cs_d = 3'h4;
      2'h2:    cs_d = 3'h6;
      2'h3:    cs_d = 3'h7;
      default: cs_d = 3'h0;
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (I_STOP_INSN && lpm_q != `RCPM_LPM_RUN && !wake) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // Straps are caught by a clocked process after reset release, never by the reset itself.
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_seen_q        <= 1'b0;
      cfg_done_q        <= 1'b0;
      O_MASTER_MODE     <= 1'b1;
      O_OPMODE_RESERVED <= 1'b0;
      O_BOOT_SIZE       <= `RCPM_BOOT_16;
      O_FULL_DRIVE      <= 1'b0;
      O_CLOCK_MODE      <= 2'h0;
      O_CS_ENABLE       <= 3'h0;
      O_JTAG_SEL        <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
      if (!rst_seen_q) begin
        cfg_done_q   <= 1'b1;
        O_CLOCK_MODE <= {I_CLOCK_MODE_SEL_HI, I_CLOCK_MODE_SEL_LO};
        O_JTAG_SEL   <= I_DEBUG_SEL;
        if (!I_CFG_STRAP_ENABLE_N) begin
          O_MASTER_MODE     <= (I_OPMODE_STRAP == `RCPM_OPMODE_MASTER);
          O_OPMODE_RESERVED <= (I_OPMODE_STRAP != `RCPM_OPMODE_MASTER);
          O_BOOT_SIZE       <= boot_d;
          O_FULL_DRIVE      <= I_DRIVE_STRAP;
          O_CS_ENABLE       <= cs_d;
        end else begin
          O_MASTER_MODE     <= 1'b1;
          O_OPMODE_RESERVED <= 1'b0;
          O_BOOT_SIZE       <= `RCPM_BOOT_16;
          O_FULL_DRIVE      <= 1'b0;
          O_CS_ENABLE       <= 3'h0;
        end
      end
    end
  end

  // Software registers and the low-power sequencer.
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lpm_q        <= `RCPM_LPM_RUN;
      cko_off_q    <= 1'b0;
      periph_dis_q <= {`RCPM_PERIPH_W{1'b0}};
      state_q      <= ST_RUN;
      O_RDATA      <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (I_WR && I_ADDR == `RCPM_OFF_LPCTRL) begin
        lpm_q     <= I_WDATA[`RCPM_LPCTRL_LPM_LSB +: 2];
        cko_off_q <= I_WDATA[`RCPM_LPCTRL_CKO_BIT];
      end
      if (I_WR && I_ADDR == `RCPM_OFF_PERIPH) begin
        periph_dis_q <= I_WDATA[`RCPM_PERIPH_W-1:0];
      end
      O_RDATA <= 32'h0000_0000;
      if (I_RD) begin
        case (I_ADDR)
          `RCPM_OFF_LPCTRL: O_RDATA <= {29'h0, cko_off_q, lpm_q};
          `RCPM_OFF_PERIPH: O_RDATA <= {24'h0, periph_dis_q};
          `RCPM_OFF_CFG:    O_RDATA <= {16'h0, O_JTAG_SEL, O_CS_ENABLE, O_CLOCK_MODE,
                                        O_FULL_DRIVE, O_BOOT_SIZE, O_OPMODE_RESERVED,
                                        O_MASTER_MODE, 5'h0};
          `RCPM_OFF_STATUS: O_RDATA <= {28'h0, cfg_done_q, lpm_q, state_q};
          default:          O_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Clock gates are registered from next state so they change with the mode itself.
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LOW_POWER_MODE_FIELD <= `RCPM_LPM_RUN;
      O_CORE_CLK_EN          <= 1'b1;
      O_MEM_CLK_EN           <= 1'b1;
      O_SYS_CLK_EN           <= 1'b1;
      O_BUS_CLOCK_OUTPUT_EN  <= 1'b1;
      O_PERIPH_CLK_EN        <= {`RCPM_PERIPH_W{1'b1}};
      O_LOW_POWER_ACTIVE     <= 1'b0;
    end else begin
      // field to clock control; doze seen by peripherals
      O_LOW_POWER_MODE_FIELD <= (state_d == ST_IDLE) ? lpm_q : `RCPM_LPM_RUN;
      O_LOW_POWER_ACTIVE     <= (state_d == ST_IDLE);
      // wait gates core and memory only
      O_CORE_CLK_EN          <= (state_d == ST_RUN);
      O_MEM_CLK_EN           <= (state_d == ST_RUN);
      O_SYS_CLK_EN           <= !(state_d == ST_IDLE && lpm_q == `RCPM_LPM_STOP);
      O_BUS_CLOCK_OUTPUT_EN  <= !cko_off_q && !(state_d == ST_IDLE && lpm_q == `RCPM_LPM_STOP);
      // stop only gates clocks so peripheral state is kept
      O_PERIPH_CLK_EN        <= ~periph_dis_q &
                                {`RCPM_PERIPH_W{!(state_d == ST_IDLE && lpm_q == `RCPM_LPM_STOP)}};
    end
  end

endmodule
`default_nettype wire

// File: rcpm_defines.vh
// Constants for the reset configuration and low-power mode block.
`ifndef RCPM_DEFINES_VH
`define RCPM_DEFINES_VH
`define RCPM_ADDR_W        4
`define RCPM_OFF_LPCTRL    4'h0
`define RCPM_OFF_PERIPH    4'h1
`define RCPM_OFF_CFG       4'h2
`define RCPM_OFF_STATUS    4'h3
`define RCPM_LPM_RUN       2'h0
`define RCPM_LPM_WAIT      2'h1
`define RCPM_LPM_DOZE      2'h2
`define RCPM_LPM_STOP      2'h3
`define RCPM_OPMODE_MASTER 3'h7
`define RCPM_BOOT_32       2'h0
`define RCPM_BOOT_16       2'h1
`define RCPM_BOOT_8        2'h2
`define RCPM_LPCTRL_LPM_LSB 0
`define RCPM_LPCTRL_CKO_BIT 2
`define RCPM_PERIPH_W      8
`define RCPM_CFG_DEF       16'h0000
`endif

// File: rcpm_monitor.sv
// Concurrent checks on the ports of the strap and low-power block.
`timescale 1ns/1ns
`default_nettype none
`include "rcpm_defines.vh"
module rcpm_monitor (
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_CFG_STRAP_ENABLE_N,
  input wire logic       I_DRIVE_STRAP,
  input wire logic       I_DEBUG_SEL,
  input wire logic       I_STOP_INSN,
  input wire logic       I_IRQ_VALID,
  input wire logic [1:0] O_BOOT_SIZE,
  input wire logic       O_FULL_DRIVE,
  input wire logic       O_JTAG_SEL,
  input wire logic [1:0] O_LOW_POWER_MODE_FIELD,
  input wire logic       O_CORE_CLK_EN,
  input wire logic       O_SYS_CLK_EN,
  input wire logic [7:0] O_PERIPH_CLK_EN,
  input wire logic       O_LOW_POWER_ACTIVE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  wire       act = O_LOW_POWER_ACTIVE;
  wire [1:0] fld = O_LOW_POWER_MODE_FIELD;
  sequence s_idle_irq;
    act && I_IRQ_VALID;
  endsequence
  a_stop_entry_cause: assert property ($rose(act) |-> $past(I_STOP_INSN))
    else $error("Idle entered without a stop");
  a_stop_halts_all: assert property (act && fld == `RCPM_LPM_STOP |-> !O_SYS_CLK_EN && O_PERIPH_CLK_EN == 8'h00)
    else $error("Stop left clocks running");
  a_wait_gates_core: assert property (act && fld == `RCPM_LPM_WAIT |-> !O_CORE_CLK_EN && O_SYS_CLK_EN)
    else $error("Wait gating wrong");
  a_doze_gates_core: assert property (act && fld == `RCPM_LPM_DOZE |-> !O_CORE_CLK_EN && O_SYS_CLK_EN)
    else $error("Doze gating wrong");
  a_irq_wakes_run: assert property (s_idle_irq |=> !act && O_CORE_CLK_EN && fld == `RCPM_LPM_RUN)
    else $error("Interrupt did not wake");
  a_run_field_zero: assert property (!act |-> fld == `RCPM_LPM_RUN)
    else $error("Field not run code while running");
  a_drive_strap_cap: assert property ($rose(I_RST_N) && !I_CFG_STRAP_ENABLE_N |=> O_FULL_DRIVE == $past(I_DRIVE_STRAP))
    else $error("Drive strap not captured");
  a_no_strap_dflt: assert property ($rose(I_RST_N) && I_CFG_STRAP_ENABLE_N |=> O_BOOT_SIZE == `RCPM_BOOT_16 && !O_FULL_DRIVE)
    else $error("Default options wrong");
  a_straps_held: assert property ($past(I_RST_N, 2) && $past(I_RST_N) |-> $stable({O_BOOT_SIZE, O_FULL_DRIVE}))
    else $error("Latched options changed");
  a_debug_route: assert property ($rose(I_RST_N) |=> O_JTAG_SEL == $past(I_DEBUG_SEL))
    else $error("Debug route wrong");
endmodule
`default_nettype wire

// File: rcpm_strap_board.sv
// Board strap model that holds the straps only through the capture edge.
`timescale 1ns/1ns
`default_nettype none
module rcpm_strap_board (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable_n,
  input  wire logic [7:0] i_pattern,
  output logic      [7:0] o_straps
);
  logic held_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      held_q <= 1'b0;
    else
      held_q <= 1'b1;
  end
  // straps held while enabled, until the first clock after reset.
  // Released straps flip so that a late sample is caught.
  assign o_straps = (!i_enable_n && !held_q) ? i_pattern : ~i_pattern;
endmodule
`default_nettype wire

// File: test_reset_config_and_low_power_modes.sv
// Self-checking bench for the strap capture and low-power block.
`timescale 1ns/1ns
`default_nettype none
`include "rcpm_defines.vh"
module test_reset_config_and_low_power_modes;
  logic clk, rst_n, wr, rd, en_n, ckh, ckl, dbg, stp, breakpoint_request_n_n, dreq, irq;
  logic [3:0] addr;
  logic [31:0] wd, rdata, v;
  logic [7:0] pat, st, per;
  logic mm, rsv, full, jtag, core, mem, sys, bco, act;
  logic [1:0] boot, ckm, fld;
  logic [2:0] cs;
  int errors = 0;
  int check_count = 0;
  rcpm_strap_board brd (.i_clk(clk), .i_rst_n(rst_n), .i_enable_n(en_n), .i_pattern(pat), .o_straps(st));
  rcpm_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
    .I_CFG_STRAP_ENABLE_N(en_n), .I_OPMODE_STRAP(st[7:5]), .I_BOOT_STRAP(st[4:3]),
    .I_DRIVE_STRAP(st[2]), .I_CLOCK_MODE_SEL_HI(ckh), .I_CLOCK_MODE_SEL_LO(ckl), .I_CS_STRAP(st[1:0]),
    .I_DEBUG_SEL(dbg), .I_STOP_INSN(stp), .I_BREAKPOINT_REQUEST_N(breakpoint_request_n_n), .I_DEBUG_REQ(dreq),
    .I_IRQ_VALID(irq), .O_RDATA(rdata), .O_MASTER_MODE(mm), .O_OPMODE_RESERVED(rsv),
    .O_BOOT_SIZE(boot), .O_FULL_DRIVE(full), .O_CLOCK_MODE(ckm), .O_CS_ENABLE(cs), .O_JTAG_SEL(jtag),
    .O_LOW_POWER_MODE_FIELD(fld), .O_CORE_CLK_EN(core), .O_MEM_CLK_EN(mem), .O_SYS_CLK_EN(sys),
    .O_BUS_CLOCK_OUTPUT_EN(bco), .O_PERIPH_CLK_EN(per), .O_LOW_POWER_ACTIVE(act));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdd(input logic [3:0] a);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Event pulse: 0 stop, 1 interrupt, 2 breakpoint, 3 debug request.
  task automatic ev(input int k);
    @(posedge clk);
    {dreq, breakpoint_request_n_n, irq, stp} <= 4'b0100 ^ (4'h1 << k);
    @(posedge clk);
    {dreq, breakpoint_request_n_n, irq, stp} <= 4'b0100;
    #1;
  endtask
  task automatic boot_with(input logic n, input logic [7:0] p, input logic [2:0] c);
    @(posedge clk);
    {rst_n, en_n, pat, ckh, ckl, dbg} <= {1'b0, n, p, c};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    errors++;
    wrap_up();
  end
  initial begin
    {rst_n, wr, rd, en_n, ckh, ckl, dbg, stp, dreq, irq, addr, wd, pat} = '0;
    breakpoint_request_n_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      boot_with(1'b0, {i[0] ? 3'h7 : 3'h3, i[1:0], i[0], i[1:0]}, {i[1:0], i[0]});
      chk("boot", i == 1 ? `RCPM_BOOT_16 : i == 2 ? `RCPM_BOOT_8 : `RCPM_BOOT_32, boot);
      chk("drive", i[0], full);
      chk("master", {i[0], !i[0]}, {mm, rsv});
      chk("cs", i == 1 ? 3'h4 : i == 2 ? 3'h6 : i == 3 ? 3'h7 : 3'h0, cs);
      chk("clkmode", {i[1:0], i[0]}, {ckm, jtag});
    end
    boot_with(1'b1, 8'h00, 3'h0);
    chk("default", {`RCPM_BOOT_16, 1'b0}, {boot, full});
    wrr(`RCPM_OFF_LPCTRL, 32'h0);
    ev(0);
    chk("run_stop", 0, act);
    for (int m = 1; m < 4; m++) begin
      wrr(`RCPM_OFF_LPCTRL, m);
      ev(0);
      chk("lowpower", {m[1:0], 3'b100, m == 3 ? 10'h000 : 10'h3FF}, {fld, act, core, mem, sys, bco, per});
      ev(m);
      chk("wake", 15'h0FFF, {fld, act, core, mem, sys, bco, per});
    end
    wrr(`RCPM_OFF_PERIPH, 32'h0F);
    wrr(`RCPM_OFF_LPCTRL, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    chk("periph", 9'h0F0, {bco, per});
    wrr(`RCPM_OFF_LPCTRL, 32'h3);
    ev(0);
    ev(1);
    chk("periph_off", 8'hF0, per);
    rdd(`RCPM_OFF_PERIPH);
    chk("rd_periph", 32'h0F, v);
    rdd(4'hF);
    chk("rd_unmapped", 32'h0, v);
    rdd(`RCPM_OFF_LPCTRL);
    chk("rd_lpctrl", 32'h3, v);
    rdd(`RCPM_OFF_STATUS);
    chk("rd_status", 32'hE, v);
    rdd(`RCPM_OFF_CFG);
    chk("rd_cfg", 32'hA0, v);
    wrap_up();
  end
endmodule
bind rcpm_top rcpm_monitor u_mon (
  .I_SYS_CLK(I_SYS_CLK),
  .I_RST_N(I_RST_N),
  .I_CFG_STRAP_ENABLE_N(I_CFG_STRAP_ENABLE_N),
  .I_DRIVE_STRAP(I_DRIVE_STRAP),
  .I_DEBUG_SEL(I_DEBUG_SEL),
  .I_STOP_INSN(I_STOP_INSN),
  .I_IRQ_VALID(I_IRQ_VALID),
  .O_BOOT_SIZE(O_BOOT_SIZE),
  .O_FULL_DRIVE(O_FULL_DRIVE),
  .O_JTAG_SEL(O_JTAG_SEL),
  .O_LOW_POWER_MODE_FIELD(O_LOW_POWER_MODE_FIELD),
  .O_CORE_CLK_EN(O_CORE_CLK_EN),
  .O_SYS_CLK_EN(O_SYS_CLK_EN),
  .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN),
  .O_LOW_POWER_ACTIVE(O_LOW_POWER_ACTIVE)
);
`default_nettype wire
